// [hdl/issl_pkg.sv]
// constants and command codes for the status reporting block
package issl_pkg;

    // ==================================================================
    // operation event bit positions
    localparam int OPB_LINK_LOST = 7;
    localparam int OPB_CAL_BAD = 6;
    localparam int OPB_TUNING_IDLE = 5;
    localparam int OPB_FRESH_READING = 4;
    localparam int OPB_LOOP_ONE_RAMP_DONE = 3;
    localparam int OPB_LOOP_TWO_RAMP_DONE = 2;
    localparam int OPB_INPUT_OVERRANGE = 1;
    localparam int OPB_ALARM_SHOWN = 0;

    // ==================================================================
    // standard event bit positions
    localparam int SEB_POWER_UP = 7;
    localparam int SEB_COMMAND_ERROR = 5;
    localparam int SEB_EXEC_ERROR = 4;
    localparam int SEB_QUERY_ERROR = 2;
    localparam int SEB_OP_DONE = 0;

    // ==================================================================
    // status summary byte bit positions
    localparam int STB_OPERATION_SUMMARY = 7;
    localparam int STB_MASTER_SUMMARY = 6;
    localparam int STB_STANDARD_EVENT_SUMMARY = 5;
    localparam int STB_OUTPUT_MESSAGE_PENDING = 4;

    // ==================================================================
    // reset values and constants
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic [7:0] EVENT_RESET = 8'h00;
    localparam logic [7:0] STD_EVENT_RESET = 8'h80;
    localparam logic [7:0] OP_DONE_REPLY = 8'h01;
    localparam int SYNC_WIDTH = 8;

    // ==================================================================
    // decoded commands from the parser
    typedef enum logic [3:0] {
        ISSL_CMD_NONE = 4'h0,
        ISSL_CMD_OP_ENABLE_SET = 4'h1,
        ISSL_CMD_OP_ENABLE_QUERY = 4'h2,
        ISSL_CMD_OP_EVENT_QUERY = 4'h3,
        ISSL_CMD_OP_CONDITION_QUERY = 4'h4,
        ISSL_CMD_SR_ENABLE_SET = 4'h5,
        ISSL_CMD_SR_ENABLE_QUERY = 4'h6,
        ISSL_CMD_STATUS_QUERY = 4'h7,
        ISSL_CMD_STD_ENABLE_SET = 4'h8,
        ISSL_CMD_STD_ENABLE_QUERY = 4'h9,
        ISSL_CMD_STD_EVENT_QUERY = 4'ha,
        ISSL_CMD_CLEAR_STATUS = 4'hb,
        ISSL_CMD_OP_DONE_ARM = 4'hc,
        ISSL_CMD_OP_DONE_QUERY = 4'hd
    } issl_cmd_t;

endpackage

// [hdl/issl_pin_sync.sv]
// three-stage synchroniser with agreement filter for condition pins
`timescale 1ns/1ps

module issl_pin_sync
    import issl_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic [SYNC_WIDTH-1:0] pin_in,
    output logic [SYNC_WIDTH-1:0] level_out
);

    // ==================================================================
    // synchroniser chain
    logic [SYNC_WIDTH-1:0] stage_one;
    logic [SYNC_WIDTH-1:0] stage_two;
    logic [SYNC_WIDTH-1:0] stage_three;
    logic [SYNC_WIDTH-1:0] next_level;

    // a bit changes only once stages two and three agree
    assign next_level = (stage_two & stage_three) | (level_out & (stage_two | stage_three));

    // first stage feeds only the second
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            stage_one <= '0;
            stage_two <= '0;
            stage_three <= '0;
            level_out <= '0;
        end
        else
        begin
            stage_one <= pin_in;
            stage_two <= stage_one;
            stage_three <= stage_two;
            level_out <= next_level;
        end
    end

endmodule

// [hdl/issl_status_core.sv]
// status byte, event registers and service request logic
//
// Summary of operation
// [R1] Op bit 7 on link loss, bit 6 on bad calibration.
// [R2] Op bit 5 while tuning idle, bit 4 on fresh reading.
// [R3] Op bit 3 loop one ramp done, bit 2 loop two.
// [R4] Op bit 1 on overrange, bit 0 on shown alarm.
// [R5] Op enable mask set and read; enabled events form operation summary.
// [R6] Op event read returns latched bits, then clears them.
// [R7] Op condition query returns live unlatched condition bits.
// [R8] Summary bits unlatched; clearing an event register clears its summary.
// [R9] Status bit 7 from enabled op events, bit 5 from enabled standard events.
// [R10] Status bit 4 set while the output buffer holds a message.
// [R11] Master summary bit 6 set when an enabled summary bit is set.
// [R12] Service request line asserted on a rising enabled summary.
// [R13] Serial poll clears request service and the line; master summary stays.
// [R14] Master summary holds until every enabled summary bit is cleared.
// [R15] After a poll, same summary bit raises no new request until cleared.
// [R16] Status query returns poll byte, master summary in bit 6, clears nothing.
// [R17] Service request enable mask is host programmable and readable.
// [R18] Arm sets standard event bit 0 when operations finish; commands continue.
// [R19] Done query holds bus until idle, then buffers 1; bit 0 untouched.
// [R20] Host sends only reset while a done query is pending.
// [R21] Host enables 32 in both masks for a request on command error.
// [R22] Standard events: bit 7 power-up, 5, 4, 2 overflow, 0 done.
// [R23] Clear status clears all event registers and their summary bits.
// [R24] Enables take the written value; zero or power-up clears them.
// [R25] Summary and request logic re-evaluated each cycle.
`timescale 1ns/1ps

module issl_status_core
    import issl_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic link_lost_in,
    input wire logic cal_bad_in,
    input wire logic tuning_idle_in,
    input wire logic fresh_reading_in,
    input wire logic loop_one_ramp_done_in,
    input wire logic loop_two_ramp_done_in,
    input wire logic input_overrange_in,
    input wire logic alarm_shown_in,
    input wire logic command_error_event_in,
    input wire logic exec_error_event_in,
    input wire logic ops_busy_in,
    input wire logic cmd_valid_in,
    input wire logic [3:0] cmd_code_in,
    input wire logic [7:0] cmd_data_in,
    input wire logic reply_take_in,
    input wire logic serial_poll_in,
    output logic [7:0] reply_data_out,
    output logic reply_valid_out,
    output logic bus_hold_out,
    output logic [7:0] poll_data_out,
    output logic poll_valid_out,
    output logic srq_out,
    output logic [7:0] status_summary_byte_out
);

    // ==================================================================
    // state
    logic [7:0] operation_condition;
    logic [7:0] operation_condition_d;
    logic [7:0] operation_event_latch;
    logic [7:0] operation_event_enable;
    logic [7:0] std_event_latch;
    logic [7:0] std_event_enable;
    logic [7:0] service_request_enable;
    logic [3:0] srq_source_d;
    logic request_service_flag;
    logic op_done_armed;
    logic op_done_query_pending;
    logic [7:0] raw_pins;

    // ==================================================================
    // decoding helpers
    function automatic logic is_cmd(input issl_cmd_t c);
        is_cmd = cmd_valid_in && (cmd_code_in == c);
    endfunction

    // true when any bit of an event register survives its enable mask
    function automatic logic any_enabled(input logic [7:0] ev, input logic [7:0] en);
        any_enabled = |(ev & en);
    endfunction

    // gather condition pins in their documented bit order
    // [R1] link loss and calibration bits
    // [R2] tuning idle and fresh reading bits
    // [R3] ramp done bits
    // [R4] overrange and alarm bits
    assign raw_pins = {link_lost_in, cal_bad_in, tuning_idle_in, fresh_reading_in,
                       loop_one_ramp_done_in, loop_two_ramp_done_in,
                       input_overrange_in, alarm_shown_in};

    // pins arrive from other logic on other clocks, so filter them
    issl_pin_sync u_pin_sync (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .pin_in(raw_pins),
        .level_out(operation_condition)
    );

    // ==================================================================
    // command decode
    wire cmd_op_en_set = is_cmd(ISSL_CMD_OP_ENABLE_SET);
    wire cmd_op_en_qry = is_cmd(ISSL_CMD_OP_ENABLE_QUERY);
    wire cmd_op_ev_qry = is_cmd(ISSL_CMD_OP_EVENT_QUERY);
    wire cmd_op_cond_qry = is_cmd(ISSL_CMD_OP_CONDITION_QUERY);
    wire cmd_sre_set = is_cmd(ISSL_CMD_SR_ENABLE_SET);
    wire cmd_sre_qry = is_cmd(ISSL_CMD_SR_ENABLE_QUERY);
    wire cmd_stb_qry = is_cmd(ISSL_CMD_STATUS_QUERY);
    wire cmd_std_en_set = is_cmd(ISSL_CMD_STD_ENABLE_SET);
    wire cmd_std_en_qry = is_cmd(ISSL_CMD_STD_ENABLE_QUERY);
    wire cmd_std_ev_qry = is_cmd(ISSL_CMD_STD_EVENT_QUERY);
    wire cmd_clear = is_cmd(ISSL_CMD_CLEAR_STATUS);
    wire cmd_done_arm = is_cmd(ISSL_CMD_OP_DONE_ARM);
    wire cmd_done_qry = is_cmd(ISSL_CMD_OP_DONE_QUERY);

    // ==================================================================
    // operation event latch
    logic [7:0] op_rise;
    logic [7:0] op_clear_mask;
    logic [7:0] next_operation_event_latch;

    // a bit latches on the rising edge of its condition
    assign op_rise = operation_condition & ~operation_condition_d;
    // [R6] read then clear
    // [R23] clear status empties it
    assign op_clear_mask = (cmd_op_ev_qry || cmd_clear) ? 8'hff : 8'h00;
    // new events win over a clear in the same cycle
    assign next_operation_event_latch = (operation_event_latch & ~op_clear_mask) | op_rise;

    // ==================================================================
    // standard event latch
    logic [7:0] std_set;
    logic [7:0] std_clear_mask;
    logic [7:0] next_std_event_latch;
    logic reply_overflow;
    logic done_arm_fire;
    logic reply_load;

    // any reply while the buffer is still full is lost
    assign reply_overflow = reply_valid_out && !reply_take_in && reply_load;
    // [R18] fires once started operations finish
    assign done_arm_fire = op_done_armed && !ops_busy_in;

    // [R22] standard event sources
    always_comb
    begin
        std_set = 8'h00;
        std_set[SEB_COMMAND_ERROR] = command_error_event_in;
        std_set[SEB_EXEC_ERROR] = exec_error_event_in;
        std_set[SEB_QUERY_ERROR] = reply_overflow;
        std_set[SEB_OP_DONE] = done_arm_fire;
    end

    // [R23] read or clear status empties it
    assign std_clear_mask = (cmd_std_ev_qry || cmd_clear) ? 8'hff : 8'h00;
    assign next_std_event_latch = (std_event_latch & ~std_clear_mask) | std_set;

    // ==================================================================
    // summary bits, all combinational
    logic operation_summary;
    logic standard_event_summary;
    logic output_message_pending;
    logic master_summary_flag;
    logic [7:0] summary_bits;
    logic [3:0] srq_source;
    logic srq_rise;
    logic next_request_service_flag;
    logic [7:0] status_byte;
    logic [7:0] poll_byte;

    // [R5] enabled op events form the operation summary
    // [R9] bit 7 from op events, bit 5 from standard events
    // [R8] no latching here
    assign operation_summary = any_enabled(operation_event_latch, operation_event_enable);
    assign standard_event_summary = any_enabled(std_event_latch, std_event_enable);
    // [R10] message pending while the buffer holds a byte
    assign output_message_pending = reply_valid_out;

    always_comb
    begin
        summary_bits = 8'h00;
        summary_bits[STB_OPERATION_SUMMARY] = operation_summary;
        summary_bits[STB_STANDARD_EVENT_SUMMARY] = standard_event_summary;
        summary_bits[STB_OUTPUT_MESSAGE_PENDING] = output_message_pending;
    end

    // [R11] enabled summary sets master summary
    // [R14] held while any enabled summary stays set
    assign master_summary_flag = any_enabled(summary_bits, service_request_enable);
    assign srq_source = {summary_bits[7] & service_request_enable[7],
                         summary_bits[5] & service_request_enable[5],
                         summary_bits[4] & service_request_enable[4], 1'b0};
    // [R12] request on a low-to-high enabled summary
    // [R15] a bit still set after a poll cannot raise another
    assign srq_rise = |(srq_source & ~srq_source_d);
    // [R13] poll clears request service, a new rise wins
    assign next_request_service_flag = srq_rise || (request_service_flag && !serial_poll_in);

    // [R16] query shows master summary in bit 6
    always_comb
    begin
        status_byte = summary_bits;
        status_byte[STB_MASTER_SUMMARY] = master_summary_flag;
        poll_byte = summary_bits;
        poll_byte[STB_MASTER_SUMMARY] = request_service_flag;
    end

    // ==================================================================
    // reply selection
    logic [7:0] reply_value;
    logic done_query_fire;

    // [R19] buffer 1 once the pending operations are done
    assign done_query_fire = op_done_query_pending && !ops_busy_in;

    always_comb
    begin
        reply_load = 1'b1;
        reply_value = 8'h00;
        if (done_query_fire)
        begin
            reply_value = OP_DONE_REPLY;
        end
        else if (cmd_op_en_qry)
        begin
            reply_value = operation_event_enable;
        end
        else if (cmd_op_ev_qry)
        begin
            reply_value = operation_event_latch;
        end
        else if (cmd_op_cond_qry)
        begin
            // [R7] live condition bits
            reply_value = operation_condition;
        end
        else if (cmd_sre_qry)
        begin
            // [R17] mask reads back
            reply_value = service_request_enable;
        end
        else if (cmd_stb_qry)
        begin
            reply_value = status_byte;
        end
        else if (cmd_std_en_qry)
        begin
            reply_value = std_event_enable;
        end
        else if (cmd_std_ev_qry)
        begin
            reply_value = std_event_latch;
        end
        else
        begin
            reply_load = 1'b0;
        end
    end

    // ==================================================================
    // condition history and request state
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            operation_condition_d <= 8'h00;
            operation_event_latch <= EVENT_RESET;
            std_event_latch <= STD_EVENT_RESET;
            srq_source_d <= 4'h0;
            request_service_flag <= 1'b0;
        end
        else
        begin
            operation_condition_d <= operation_condition;
            operation_event_latch <= next_operation_event_latch;
            std_event_latch <= next_std_event_latch;
            srq_source_d <= srq_source;
            request_service_flag <= next_request_service_flag;
        end
    end

    // ==================================================================
    // enable registers
    // [R24] take the written byte, power-up clears
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            operation_event_enable <= ENABLE_RESET;
            service_request_enable <= ENABLE_RESET;
            std_event_enable <= ENABLE_RESET;
        end
        else
        begin
            // [R5] op enable command
            if (cmd_op_en_set)
                operation_event_enable <= cmd_data_in;
            // [R17] service request mask; bit 6 is not a summary source
            if (cmd_sre_set)
                service_request_enable <= cmd_data_in & ~8'h40;
            if (cmd_std_en_set)
                std_event_enable <= cmd_data_in;
        end
    end

    // ==================================================================
    // operation complete tracking
    // arm waits at least one cycle so the started work can raise busy
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            op_done_armed <= 1'b0;
            op_done_query_pending <= 1'b0;
        end
        else
        begin
            // [R18] other commands keep flowing while armed
            op_done_armed <= cmd_done_arm || (op_done_armed && ops_busy_in);
            // [R19] bus held until done
            op_done_query_pending <= cmd_done_qry || (op_done_query_pending && ops_busy_in);
        end
    end

    // ==================================================================
    // output buffer, one byte deep
    // a new byte wins over a take in the same cycle
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            reply_data_out <= 8'h00;
            reply_valid_out <= 1'b0;
        end
        else if (reply_load && (!reply_valid_out || reply_take_in))
        begin
            reply_data_out <= reply_value;
            reply_valid_out <= 1'b1;
        end
        else if (reply_take_in)
        begin
            reply_valid_out <= 1'b0;
        end
    end

    // ==================================================================
    // registered outputs
    // [R25] status byte follows every cycle with one register delay
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            status_summary_byte_out <= 8'h00;
            srq_out <= 1'b0;
            bus_hold_out <= 1'b0;
            poll_data_out <= 8'h00;
            poll_valid_out <= 1'b0;
        end
        else
        begin
            status_summary_byte_out <= status_byte;
            // [R12] request line follows request service
            srq_out <= next_request_service_flag;
            bus_hold_out <= cmd_done_qry || (op_done_query_pending && ops_busy_in);
            poll_valid_out <= serial_poll_in;
            // [R16] poll shows request service in bit 6
            if (serial_poll_in)
                poll_data_out <= poll_byte;
        end
    end

endmodule

// [sim/issl_status_core_assertions.sv]
// concurrent checks on the ports of the status reporting block
`timescale 1ns/1ps

module issl_status_core_assertions
    import issl_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic ops_busy_in,
    input wire logic cmd_valid_in,
    input wire logic [3:0] cmd_code_in,
    input wire logic reply_take_in,
    input wire logic serial_poll_in,
    input wire logic [7:0] reply_data_out,
    input wire logic reply_valid_out,
    input wire logic bus_hold_out,
    input wire logic [7:0] poll_data_out,
    input wire logic poll_valid_out,
    input wire logic srq_out,
    input wire logic [7:0] status_summary_byte_out
);
    // ==========
    // single clock domain
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (rst_in);

    // ==========
    // steps of the done query
    sequence s_done_query;
        cmd_valid_in && cmd_code_in == ISSL_CMD_OP_DONE_QUERY;
    endsequence
    sequence s_ops_finished;
        bus_hold_out && !ops_busy_in && !reply_valid_out;
    endsequence

    a_done_holds_bus: assert property (s_done_query |=> bus_hold_out)
        else $error("no bus hold");
    a_hold_while_busy: assert property (bus_hold_out && ops_busy_in |=> bus_hold_out)
        else $error("hold dropped early");
    a_done_reply_one: assert property (s_ops_finished |=> !bus_hold_out && reply_valid_out
        && reply_data_out == OP_DONE_REPLY)
        else $error("bad done reply");

    // ==========
    // output buffer and its summary bit
    a_status_reply: assert property (cmd_valid_in && cmd_code_in == ISSL_CMD_STATUS_QUERY
        && !reply_valid_out |=> reply_valid_out)
        else $error("no status reply");
    a_reply_stands: assert property (reply_valid_out && !reply_take_in
        |=> reply_valid_out && $stable(reply_data_out))
        else $error("reply lost");
    a_take_empties: assert property (reply_valid_out && reply_take_in && !cmd_valid_in
        |=> !reply_valid_out)
        else $error("buffer not emptied");
    a_mav_bit: assert property ($stable(reply_valid_out)
        |-> status_summary_byte_out[STB_OUTPUT_MESSAGE_PENDING] == reply_valid_out)
        else $error("bit 4 wrong");

    // ==========
    // serial poll answer
    a_poll_pulse: assert property (serial_poll_in |=> poll_valid_out)
        else $error("no poll answer");
    a_poll_single: assert property (serial_poll_in ##1 !serial_poll_in |=> !poll_valid_out)
        else $error("poll answer too long");
    a_poll_rqs_bit: assert property (serial_poll_in
        |=> poll_data_out[STB_MASTER_SUMMARY] == $past(srq_out))
        else $error("poll bit 6 wrong");
endmodule

// [sim/issl_host_model.sv]
// bus controller model: commands, buffer reads and serial polls
`timescale 1ns/1ps

module issl_host_model
    import issl_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic reply_valid_in,
    input wire logic [7:0] reply_data_in,
    input wire logic bus_hold_in,
    output logic cmd_valid_out,
    output logic [3:0] cmd_code_out,
    output logic [7:0] cmd_data_out,
    output logic reply_take_out,
    output logic serial_poll_out
);
    int hang = 0;

    // idle levels at time zero
    initial
    begin
        cmd_valid_out = 1'b0;
        cmd_code_out = 4'h0;
        cmd_data_out = 8'h00;
        reply_take_out = 1'b0;
        serial_poll_out = 1'b0;
    end

    // one strobe; called and left at a falling edge
    task automatic send(input issl_cmd_t code, input logic [7:0] data);
        int n;
        n = 0;
        // nothing goes out while the bus is held, for up to 60 cycles
        while (bus_hold_in !== 1'b0 && n < 60)
        begin
            @(negedge clk_sys_in);
            n++;
        end
        if (n == 60)
            hang++;
        // enable values go out as plain binary weights
        cmd_valid_out = 1'b1;
        cmd_code_out = code;
        cmd_data_out = data;
        @(negedge clk_sys_in);
        cmd_valid_out = 1'b0;
        // released lines show garbage, not the old value
        cmd_code_out = ~code;
        cmd_data_out = ~data;
    endtask

    // wait a bounded time for a byte, then read it out
    task automatic get(output logic [7:0] d, output bit ok);
        ok = 1'b0;
        d = 8'hxx;
        for (int n = 0; n < 60 && !ok; n++)
        begin
            if (reply_valid_in === 1'b1)
            begin
                d = reply_data_in;
                ok = 1'b1;
                reply_take_out = 1'b1;
            end
            @(negedge clk_sys_in);
            reply_take_out = 1'b0;
        end
    endtask

    // one-cycle serial poll
    task automatic poll();
        serial_poll_out = 1'b1;
        @(negedge clk_sys_in);
        serial_poll_out = 1'b0;
    endtask
endmodule

// [sim/issl_status_core_tb.sv]
// self-checking bench for the status reporting block
`timescale 1ns/1ps

module issl_status_core_tb
    import issl_pkg::*;
;
    logic clk_sys_in, rst_in, command_error_event, exe, busy, cmd_valid, take, poll;
    logic reply_valid, hold, poll_valid, srq;
    logic [3:0] code;
    logic [7:0] cond, cdata, reply_data, poll_data, stat;
    int n_mismatch = 0;
    int total_checks = 0;

    issl_status_core dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .link_lost_in(cond[7]), .cal_bad_in(cond[6]), .tuning_idle_in(cond[5]),
        .fresh_reading_in(cond[4]), .loop_one_ramp_done_in(cond[3]),
        .loop_two_ramp_done_in(cond[2]), .input_overrange_in(cond[1]),
        .alarm_shown_in(cond[0]), .command_error_event_in(command_error_event),
        .exec_error_event_in(exe), .ops_busy_in(busy), .cmd_valid_in(cmd_valid),
        .cmd_code_in(code), .cmd_data_in(cdata), .reply_take_in(take),
        .serial_poll_in(poll), .reply_data_out(reply_data), .reply_valid_out(reply_valid),
        .bus_hold_out(hold), .poll_data_out(poll_data), .poll_valid_out(poll_valid),
        .srq_out(srq), .status_summary_byte_out(stat));

    issl_host_model host (.clk_sys_in(clk_sys_in), .reply_valid_in(reply_valid),
        .reply_data_in(reply_data), .bus_hold_in(hold), .cmd_valid_out(cmd_valid),
        .cmd_code_out(code), .cmd_data_out(cdata), .reply_take_out(take),
        .serial_poll_out(poll));

    // 40 MHz clock
    initial
    begin
        clk_sys_in = 1'b0;
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end

    // ==========
    // shared tasks
    task automatic final_report();
        n_mismatch += host.hang;
        if (n_mismatch == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys_in);
    endtask
    task automatic rd(input logic [7:0] exp);
        logic [7:0] d;
        bit ok;
        host.get(d, ok);
        if (!ok)
        begin
            n_mismatch++;
            final_report();
        end
        chk(d, exp);
    endtask
    task automatic qc(input issl_cmd_t c, input logic [7:0] exp);
        host.send(c, 8'h00);
        rd(exp);
    endtask
    task automatic pulse_cme();
        command_error_event = 1'b1;
        cyc(1);
        command_error_event = 1'b0;
        cyc(3);
    endtask

    // ==========
    // scenarios
    task automatic t_reset_values();
        chk(stat, 8'h00);
        qc(ISSL_CMD_STD_EVENT_QUERY, 8'h80);
        qc(ISSL_CMD_OP_ENABLE_QUERY, 8'h00);
        qc(ISSL_CMD_SR_ENABLE_QUERY, 8'h00);
        qc(ISSL_CMD_STD_ENABLE_QUERY, 8'h00);
    endtask
    task automatic t_op_events();
        for (int i = 0; i < 8; i++)
        begin
            cond = 8'h01 << i;
            cyc(6);
            qc(ISSL_CMD_OP_CONDITION_QUERY, 8'h01 << i);
            cond = 8'h00;
            cyc(6);
        end
        qc(ISSL_CMD_OP_EVENT_QUERY, 8'hff);
        qc(ISSL_CMD_OP_EVENT_QUERY, 8'h00);
    endtask
    task automatic t_enables();
        host.send(ISSL_CMD_OP_ENABLE_SET, 8'ha5);
        qc(ISSL_CMD_OP_ENABLE_QUERY, 8'ha5);
        host.send(ISSL_CMD_SR_ENABLE_SET, 8'hff);
        qc(ISSL_CMD_SR_ENABLE_QUERY, 8'hbf);
        host.send(ISSL_CMD_SR_ENABLE_SET, 8'h00);
        qc(ISSL_CMD_SR_ENABLE_QUERY, 8'h00);
        host.poll();
    endtask
    task automatic t_service_request();
        // command error routed to a request
        host.send(ISSL_CMD_STD_ENABLE_SET, 8'h20);
        host.send(ISSL_CMD_SR_ENABLE_SET, 8'h20);
        pulse_cme();
        chk({7'h00, srq}, 8'h01);
        chk(stat, 8'h60);
        qc(ISSL_CMD_STATUS_QUERY, 8'h60);
        host.poll();
        chk(poll_data, 8'h60);
        cyc(2);
        chk({7'h00, srq}, 8'h00);
        chk(stat, 8'h60);
        pulse_cme();
        chk({7'h00, srq}, 8'h00);
        qc(ISSL_CMD_STD_EVENT_QUERY, 8'h20);
        cyc(2);
        chk(stat, 8'h00);
        pulse_cme();
        chk({7'h00, srq}, 8'h01);
        host.poll();
        host.send(ISSL_CMD_CLEAR_STATUS, 8'h00);
        cyc(3);
        chk(stat, 8'h00);
    endtask
    task automatic t_buffer_and_done();
        host.send(ISSL_CMD_STD_ENABLE_SET, 8'h00);
        host.send(ISSL_CMD_STATUS_QUERY, 8'h00);
        cyc(2);
        chk(stat, 8'h10);
        // second query finds the buffer full
        host.send(ISSL_CMD_STATUS_QUERY, 8'h00);
        exe = 1'b1;
        cyc(1);
        exe = 1'b0;
        busy = 1'b1;
        host.send(ISSL_CMD_OP_DONE_ARM, 8'h00);
        rd(8'h00);
        cyc(3);
        chk(stat, 8'h00);
        qc(ISSL_CMD_STD_ENABLE_QUERY, 8'h00);
        busy = 1'b0;
        cyc(3);
        qc(ISSL_CMD_STD_EVENT_QUERY, 8'h15);
        busy = 1'b1;
        host.send(ISSL_CMD_OP_DONE_QUERY, 8'h00);
        cyc(4);
        chk({6'h00, hold, reply_valid}, 8'h02);
        busy = 1'b0;
        rd(OP_DONE_REPLY);
        qc(ISSL_CMD_STD_EVENT_QUERY, 8'h00);
    endtask

    // main sequence
    initial
    begin
        rst_in = 1'b1;
        cond = 8'h00;
        command_error_event = 1'b0;
        exe = 1'b0;
        busy = 1'b0;
        cyc(6);
        rst_in = 1'b0;
        cyc(2);
        t_reset_values();
        t_op_events();
        t_enables();
        t_service_request();
        t_buffer_and_done();
        final_report();
    end
endmodule

bind issl_status_core issl_status_core_assertions chk_i (.clk_sys_in(clk_sys_in),
    .rst_in(rst_in), .ops_busy_in(ops_busy_in), .cmd_valid_in(cmd_valid_in),
    .cmd_code_in(cmd_code_in), .reply_take_in(reply_take_in),
    .serial_poll_in(serial_poll_in), .reply_data_out(reply_data_out),
    .reply_valid_out(reply_valid_out), .bus_hold_out(bus_hold_out),
    .poll_data_out(poll_data_out), .poll_valid_out(poll_valid_out), .srq_out(srq_out),
    .status_summary_byte_out(status_summary_byte_out));
